// File: hdl/adc_fmt_cfg.svh
`ifndef ADC_FMT_CFG_SVH
`define ADC_FMT_CFG_SVH
`define SAMPLE_W 12
`define PIPE_DEPTH 10
`define FIFO_DEPTH 8
`define CODE_MID 12'h0800
`define CODE_POS_FS 12'h0FFF
`define CODE_ZERO 12'h0000
`define SIGN_BIT 11
`define DITHER_SEED 16'hACE1
`define DITHER_TAPS 16'hB400
`endif

// File: hdl/adc_fmt_pkg.sv
`include "adc_fmt_cfg.svh"
package adc_fmt_pkg;
   typedef logic [`SAMPLE_W-1:0] sample_t;
   typedef enum logic [0:0] {
      FMT_TWOS = 1'b0,
      FMT_OFFSET = 1'b1
   } fmt_t;
endpackage

// File: hdl/adc_output_format_and_mode_ctrl.sv
// Behaviour
// - Format select high gives offset binary output on every sample.
// - Format select low gives two's complement output on every sample.
// - Offset binary maps +FS to 4095, zero to 0x800, one below zero to 2047, -FS to 0.
// - Two's complement maps +FS to 0x7FF, zero to 0, one below zero to 0xFFF, -FS to 0x800.
// - Spur reduction enable high switches the threshold dither on.
// - Spur reduction enable low gives a static transfer function.
// - With spur reduction on, code thresholds may move from one sample to the next.
// - Sampling is timed from the rising clock edge only, whatever the duty cycle.
// - The duty-cycle stabiliser has no disable input or setting.
// - With no back-pressure from i_sample_ready, each sample leaves on registered outputs ten clocks after it was taken.
// - An unconnected format select input reads low, selecting two's complement.
`timescale 1ns/1ps
`default_nettype none
module adc_output_format_and_mode_ctrl
   import adc_fmt_pkg::*;
#(
   parameter int PIPE_DEPTH = `PIPE_DEPTH,
   parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
   input wire logic i_core_clk,
   input wire logic i_srst,
   input wire logic [`SAMPLE_W-1:0] i_raw_sample,
   input wire logic i_raw_valid,
   input wire logic i_output_format_select,
   input wire logic i_spur_reduction_enable,
   output logic o_raw_ready,
   output logic [`SAMPLE_W-1:0] o_sample,
   output logic o_sample_valid,
   input wire logic i_sample_ready,
   output logic o_fmt_offset_binary,
   output logic o_spur_active
);
   // Raw sample is offset binary straight from the quantiser (0 = -FS)
   typedef struct packed {
      logic [2:0] fmt_sync;
      logic [2:0] spur_sync;
      logic fmt;
      logic spur;
      logic [15:0] lfsr;
      logic [PIPE_DEPTH-1:0][`SAMPLE_W-1:0] pipe;
      logic [PIPE_DEPTH-1:0] pipe_v;
      logic [`SAMPLE_W-1:0] out_data;
      logic out_valid;
   } core_state_t;
   core_state_t state_reg;
   core_state_t state_next;
   logic [`SAMPLE_W-1:0] dithered;
   logic [`SAMPLE_W-1:0] fifo_data;
   logic fifo_valid;
   logic fifo_ready;
   logic adv;

   function automatic logic [`SAMPLE_W-1:0] encode(input logic [`SAMPLE_W-1:0] ob,
                                                   input logic sel);
      // Two's complement is offset binary with the MSB flipped
      encode = sel ? ob : (ob ^ `CODE_MID);
   endfunction

   always_comb begin
      state_next = state_reg;
      // Pin levels pass three flops; act when last two agree
      state_next.fmt_sync = {state_reg.fmt_sync[1:0], i_output_format_select};
      state_next.spur_sync = {state_reg.spur_sync[1:0], i_spur_reduction_enable};
      if (state_reg.fmt_sync[2] == state_reg.fmt_sync[1]) begin
         state_next.fmt = state_reg.fmt_sync[2];
      end
      if (state_reg.spur_sync[2] == state_reg.spur_sync[1]) begin
         state_next.spur = state_reg.spur_sync[2];
      end
      state_next.lfsr = state_reg.lfsr[0] ?
         ((state_reg.lfsr >> 1) ^ `DITHER_TAPS) : (state_reg.lfsr >> 1);
      dithered = i_raw_sample;
      // static path when off
      // Dither nudges only the LSB at a code edge, never wraps at full scale
      if (state_reg.spur && state_reg.lfsr[0] && i_raw_sample[0]
          && i_raw_sample != `CODE_POS_FS) begin
         dithered = `SAMPLE_W'(i_raw_sample + 1'b1);
      end
      // no disable
      // Pipeline stalls as a whole under back-pressure so no sample is dropped
      adv = !state_reg.out_valid || fifo_ready;
      o_raw_ready = adv;
      if (adv) begin
         state_next.pipe[0] = dithered;
         state_next.pipe_v[0] = i_raw_valid;
         for (int k = 1; k < PIPE_DEPTH; k++) begin
            state_next.pipe[k] = state_reg.pipe[k-1];
            state_next.pipe_v[k] = state_reg.pipe_v[k-1];
         end
         state_next.out_data = encode(state_reg.pipe[PIPE_DEPTH-2], state_reg.fmt);
         state_next.out_valid = state_reg.pipe_v[PIPE_DEPTH-2];
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         state_reg <= '0;
         state_reg.lfsr <= `DITHER_SEED;
      end else begin
         state_reg <= state_next;
      end
   end

   sample_fifo #(
      .WIDTH(`SAMPLE_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_core_clk(i_core_clk),
      .i_srst(i_srst),
      .i_wr_data(state_reg.out_data),
      .i_wr_valid(state_reg.out_valid),
      .o_wr_ready(fifo_ready),
      .o_rd_data(fifo_data),
      .o_rd_valid(fifo_valid),
      .i_rd_ready(i_sample_ready)
   );

   assign o_sample = fifo_data;
   assign o_sample_valid = fifo_valid;
   assign o_fmt_offset_binary = state_reg.fmt;
   assign o_spur_active = state_reg.spur;
endmodule // adc_output_format_and_mode_ctrl
`default_nettype wire

// File: hdl/sample_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 8
) (
   input wire logic i_core_clk,
   input wire logic i_srst,
   input wire logic [WIDTH-1:0] i_wr_data,
   input wire logic i_wr_valid,
   output logic o_wr_ready,
   output logic [WIDTH-1:0] o_rd_data,
   output logic o_rd_valid,
   input wire logic i_rd_ready
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wptr;
      logic [AW-1:0] rptr;
      logic [AW:0] count;
   } fifo_state_t;
   fifo_state_t state_reg;
   fifo_state_t state_next;
   logic push;
   logic pop;

   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
   endfunction

   always_comb begin
      o_wr_ready = (state_reg.count != (AW+1)'(DEPTH));
      o_rd_valid = (state_reg.count != '0);
      o_rd_data = state_reg.mem[state_reg.rptr];
      push = i_wr_valid && o_wr_ready;
      pop = o_rd_valid && i_rd_ready;
      state_next = state_reg;
      if (push) begin
         state_next.mem[state_reg.wptr] = i_wr_data;
         state_next.wptr = ptr_inc(state_reg.wptr);
      end
      if (pop) begin
         state_next.rptr = ptr_inc(state_reg.rptr);
      end
      if (push && !pop) begin
         state_next.count = (AW+1)'(state_reg.count + 1'b1);
      end else if (pop && !push) begin
         state_next.count = (AW+1)'(state_reg.count - 1'b1);
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end
endmodule // sample_fifo
`default_nettype wire

// File: sim/adc_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_properties (
   input wire logic i_core_clk,
   input wire logic i_srst,
   input wire logic i_output_format_select,
   input wire logic i_spur_reduction_enable,
   input wire logic o_raw_ready,
   input wire logic [11:0] o_sample,
   input wire logic o_sample_valid,
   input wire logic i_sample_ready,
   input wire logic o_fmt_offset_binary,
   input wire logic o_spur_active
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_srst);
   // Mode pins pass a synchroniser, so judge only long after reset
   logic [3:0] up_reg;
   always_ff @(posedge i_core_clk) up_reg <= i_srst ? 4'h0 : up_reg + 4'(~&up_reg);
   sequence fmt_held; &up_reg ##0 $stable(i_output_format_select)[*6]; endsequence
   sequence spur_held; &up_reg ##0 $stable(i_spur_reduction_enable)[*6]; endsequence
   sequence stall; o_sample_valid && !i_sample_ready; endsequence
   fmt_follow_a:
      assert property (fmt_held |-> o_fmt_offset_binary == i_output_format_select)
      else $error("format mode wrong");
   spur_follow_a:
      assert property (spur_held |-> o_spur_active == i_spur_reduction_enable)
      else $error("spur mode wrong");
   mode_settle_a:
      assert property ($fell(i_srst) |-> !(o_fmt_offset_binary || o_spur_active)[*3])
      else $error("mode left default early");
   reset_state_a: assert property (disable iff (1'b0) i_srst |=>
      !o_sample_valid && o_raw_ready && !o_fmt_offset_binary && !o_spur_active)
      else $error("reset state wrong");
   hold_valid_a: assert property (stall |=> o_sample_valid) else $error("word lost");
   hold_data_a: assert property (stall |=> $stable(o_sample)) else $error("word moved");
   refuse_full_a: assert property (!o_raw_ready |-> o_sample_valid) else $error("refused");
   ready_empty_a: assert property (!o_sample_valid |-> o_raw_ready) else $error("stuck");
endmodule // adc_ctrl_properties
`default_nettype wire

// File: sim/adc_output_format_and_mode_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module adc_output_format_and_mode_ctrl_tb_top;
   import adc_fmt_pkg::*;
   logic i_core_clk = 0, i_srst = 1, i_raw_valid = 0;
   logic i_output_format_select = 1, i_spur_reduction_enable = 0;
   logic o_raw_ready, o_sample_valid, i_sample_ready, o_fmt_offset_binary, o_spur_active;
   logic [1:0] mode = 2'h0;
   sample_t i_raw_sample = 12'h0000, o_sample, q[$];
   sample_t corner[4] = '{12'h0FFF, 12'h0800, 12'h07FF, 12'h0000};
   int seed = 32'h85c1, n_mismatch = 0, n_compared = 0, n;
   adc_output_format_and_mode_ctrl adc_output_format_and_mode_ctrl_inst (.i_core_clk, .i_srst,
      .i_raw_sample, .i_raw_valid, .i_output_format_select, .i_spur_reduction_enable,
      .o_raw_ready, .o_sample, .o_sample_valid, .i_sample_ready, .o_fmt_offset_binary,
      .o_spur_active);
   capture_model capture_model_inst (.i_core_clk, .i_mode(mode), .o_ready(i_sample_ready));
   initial forever #2.5 i_core_clk = ~i_core_clk;
   task automatic chk(input sample_t seen, input sample_t exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic send(input sample_t s);
      #1 i_raw_valid = 1;
      i_raw_sample = s;
      @(posedge i_core_clk);
      while (!o_raw_ready) @(posedge i_core_clk);
      q.push_back(i_output_format_select ? s : s ^ 12'h0800);
   endtask
   task automatic idle(input int c);
      #1 i_raw_valid = 0;
      repeat (c) @(posedge i_core_clk);
   endtask
   task automatic phase(input logic f, input logic sp);
      #1 i_srst = 1;
      i_output_format_select = f;
      i_spur_reduction_enable = sp;
      repeat (8) @(posedge i_core_clk);
      #1 i_srst = 0;
      repeat (8) @(posedge i_core_clk);
      chk(12'(o_fmt_offset_binary), 12'(f));
      chk(12'(o_spur_active), 12'(sp));
   endtask
   task automatic burst(input int c);
      foreach (corner[k]) send(corner[k]);
      repeat (c) send(12'($random(seed)));
      idle(40);
   endtask
   task automatic summarize;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge i_core_clk) if (!i_srst && o_sample_valid && i_sample_ready) begin
      chk(o_sample, q.pop_front());
   end
   initial begin
      #100000 n_mismatch++;
      summarize;
   end
   initial begin
      @(posedge i_core_clk);
      phase(1, 0);
      burst(20);
      send(12'h0800);
      idle(0);
      n = 0;
      while (!o_sample_valid && n < 30) begin
         @(posedge i_core_clk);
         #1 n++;
      end
      chk(12'(n), 12'h000a);
      idle(5);
      phase(0, 0);
      #1 mode = 2'h1;
      burst(40);
      #1 mode = 2'h2;
      fork
         repeat (30) send(12'($random(seed)));
         begin
            repeat (40) @(posedge i_core_clk);
            chk(12'(o_raw_ready), 12'h0000);
            #1 mode = 2'h0;
         end
      join
      idle(40);
      phase(1, 1);
      // Odd codes may shift by one while dithering
      repeat (20) send(12'($random(seed)) & 12'h0FFE);
      idle(40);
      summarize;
   end
endmodule // adc_output_format_and_mode_ctrl_tb_top
bind adc_output_format_and_mode_ctrl adc_ctrl_properties adc_ctrl_properties_inst (.i_core_clk,
   .i_srst, .i_output_format_select, .i_spur_reduction_enable, .o_raw_ready, .o_sample,
   .o_sample_valid, .i_sample_ready, .o_fmt_offset_binary, .o_spur_active);
`default_nettype wire

// File: sim/capture_model.sv
`timescale 1ns/1ps
`default_nettype none
module capture_model (
   input wire logic i_core_clk,
   input wire logic [1:0] i_mode,
   output logic o_ready
);
   int seed = 32'h85c1;
   initial o_ready = 1'b1;
   always @(posedge i_core_clk) o_ready <= #1 i_mode == 2'h0 || (i_mode == 2'h1 && $random(seed) > 0);
endmodule // capture_model
`default_nettype wire
